// File: core/thermal_interrupt_status_mask.sv
/*
 * interrupt status, mask and interrupt-output logic of a thermal monitor.
 * assumes the serial-bus slave presents single-cycle read and write strobes
 * on i_clk, and that the event inputs come from logic on the same clock.
 * the general input pin is asynchronous and is synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module thermal_interrupt_status_mask (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire thermal_irq_pkg::addr_t i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire thermal_irq_pkg::byte_t i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic i_int_limit_hit,
   input wire logic i_ext_limit_hit,
   input wire logic i_int_therm_hit,
   input wire logic i_ext_therm_hit,
   input wire logic i_diode_fault,
   input wire logic i_general_input_pin,
   output logic o_int_n_out,
   output logic o_int_n_oe
);
   import thermal_irq_pkg::*;

   byte_t cfg_reg, cfg_next;
   byte_t status_reg, status_next;
   byte_t mask_reg, mask_next;
   byte_t rdata_reg, rdata_next;
   logic oe_reg, oe_next;
   logic pin_meta_reg, pin_sync_reg;
   logic pin_level;
   byte_t status_view;
   byte_t hw_events;
   logic wr_cfg, wr_status, wr_mask, soft_rst;

   // pin crosses into i_clk through two flops; only the second is read
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= i_general_input_pin;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // decode and live view of the status byte
   always_comb begin
      wr_cfg = i_reg_wr && (i_reg_addr == CFG_ADDR);
      wr_status = i_reg_wr && (i_reg_addr == STATUS_ADDR);
      wr_mask = i_reg_wr && (i_reg_addr == MASK_ADDR);
      soft_rst = wr_cfg && i_reg_wdata[CFG_SOFT_RST_BIT];
      pin_level = pin_sync_reg ^ cfg_reg[CFG_INV_BIT];
      hw_events = ZERO_BYTE;
      hw_events[ST_INT_LIMIT] = i_int_limit_hit;
      hw_events[ST_EXT_LIMIT] = i_ext_limit_hit;
      hw_events[ST_INT_THERM] = i_int_therm_hit;
      hw_events[ST_EXT_THERM] = i_ext_therm_hit;
      hw_events[ST_DIODE_FAULT] = i_diode_fault;
      status_view = status_reg;
      status_view[ST_PIN_LEVEL] = pin_level;
   end

   // next register values; soft reset outranks everything, even new events
   always_comb begin
      cfg_next = cfg_reg;
      status_next = status_reg;
      mask_next = mask_reg;
      if (soft_rst) begin
         cfg_next = CFG_RESET;
         status_next = STATUS_RESET;
         mask_next = MASK_RESET;
      end else begin
         // bit 4 of config never stores, so it reads back as zero
         if (wr_cfg) begin
            cfg_next = i_reg_wdata & CFG_STORED_MASK;
         end
         if (wr_status) begin
            status_next = status_reg & ~(i_reg_wdata & W1C_BITS);
            status_next = (status_next & ~FLAG_BITS) | (i_reg_wdata & FLAG_BITS);
         end
         status_next = status_next | (hw_events & W1C_BITS);
         if (wr_mask) begin
            mask_next = i_reg_wdata;
         end
      end
      // pull low on any unmasked bit, only while the coming config value has interrupt enable (bit 1) set
      oe_next = cfg_next[CFG_INT_EN_BIT] && ((status_view & ~mask_reg) != ZERO_BYTE);
      rdata_next = rdata_reg;
      if (i_reg_rd) begin
         case (i_reg_addr)
            CFG_ADDR: rdata_next = cfg_reg;
            STATUS_ADDR: rdata_next = status_view;
            MASK_ADDR: rdata_next = mask_reg;
            default: rdata_next = ZERO_BYTE;
         endcase
      end
   end

   // registers; status resets to zero
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cfg_reg <= CFG_RESET;
         status_reg <= STATUS_RESET;
         mask_reg <= MASK_RESET;
         rdata_reg <= ZERO_BYTE;
         oe_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         rdata_reg <= rdata_next;
         oe_reg <= oe_next;
      end
   end

   assign o_reg_rdata = rdata_reg;
   assign o_int_n_out = 1'b0; // open drain: only ever pulls low
   assign o_int_n_oe = oe_reg;

   // checks
   sequence status_w1c_s(int b);
      wr_status && !soft_rst && i_reg_wdata[b] && !hw_events[b];
   endsequence

   int_limit_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_int_limit_hit && !soft_rst |=> status_reg[ST_INT_LIMIT])
      else $error("internal limit event not latched");
   ext_limit_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_ext_limit_hit && !soft_rst |=> status_reg[ST_EXT_LIMIT])
      else $error("remote limit event not latched");
   therm_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_int_therm_hit && !soft_rst |=> status_reg[ST_INT_THERM])
      else $error("internal over-temperature not latched");
   ext_therm_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_ext_therm_hit && !soft_rst |=> status_reg[ST_EXT_THERM])
      else $error("remote over-temperature not latched");
   diode_fault_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_diode_fault && !soft_rst |=> status_reg[ST_DIODE_FAULT])
      else $error("diode fault not latched");
   w1c_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      status_reg[ST_EXT_THERM] && !soft_rst && !(wr_status && i_reg_wdata[ST_EXT_THERM])
      |=> status_reg[ST_EXT_THERM])
      else $error("latched bit lost without a written one");
   w1c_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      status_w1c_s(ST_INT_LIMIT) |=> !status_reg[ST_INT_LIMIT])
      else $error("written one did not clear latched bit");
   flag_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      wr_status && !soft_rst |=> status_reg[ST_FLAG2:ST_FLAG1] == $past(i_reg_wdata[ST_FLAG2:ST_FLAG1]))
      else $error("software flags do not follow write");
   pin_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_reg_rd && i_reg_addr == STATUS_ADDR |=> o_reg_rdata[ST_PIN_LEVEL] == $past(pin_level))
      else $error("status bit 4 does not show pin level");
   // pin reaches a read three edges later, after both sync flops
   pin_invert_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_reg_rd && i_reg_addr == STATUS_ADDR
      |=> o_reg_rdata[ST_PIN_LEVEL]
         == ($past(i_general_input_pin, 3) ^ $past(cfg_reg[CFG_INV_BIT])))
      else $error("pin polarity flip wrong");
   // same-cycle event and clear: set must win
   set_wins_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      wr_status && i_reg_wdata[ST_EXT_LIMIT] && i_ext_limit_hit |=> status_reg[ST_EXT_LIMIT])
      else $error("event lost to a same-cycle clear");
   // pin bit has no storage behind it
   pin_not_stored_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !status_reg[ST_PIN_LEVEL])
      else $error("pin status bit was stored");
   // read data stands until the next read
   rdata_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data changed without a read");
   // soft reset bit never reads back as one
   soft_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !cfg_reg[CFG_SOFT_RST_BIT])
      else $error("soft reset bit did not clear itself");
   mask_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (status_view & ~mask_reg) == ZERO_BYTE |=> !o_int_n_oe)
      else $error("masked source drove interrupt");
   int_enable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_int_n_oe |-> cfg_reg[CFG_INT_EN_BIT])
      else $error("interrupt driven while disabled");
   int_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cfg_next[CFG_INT_EN_BIT] && (status_view & ~mask_reg) != ZERO_BYTE |=> o_int_n_oe)
      else $error("pending unmasked source not driven");
   soft_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      soft_rst |=> mask_reg == MASK_RESET && status_reg == STATUS_RESET && !cfg_reg[CFG_SOFT_RST_BIT])
      else $error("soft reset did not restore defaults");
   mask_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      wr_mask && !soft_rst |=> mask_reg == $past(i_reg_wdata))
      else $error("mask write lost");
   reset_zero_a: assert property (@(posedge i_clk)
      !i_rst_n |=> status_reg == STATUS_RESET && mask_reg == MASK_RESET)
      else $error("status or mask not zero after reset");
endmodule
`default_nettype wire

// File: core/thermal_irq_pkg.sv
/*
 * constants for the thermal interrupt status and mask block: register
 * offsets, bit positions and reset values.
 * assumes an 8-bit register port driven by the serial-bus slave logic.
 */
package thermal_irq_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   typedef logic [DATA_W-1:0] byte_t;
   typedef logic [ADDR_W-1:0] addr_t;

   // register offsets
   localparam addr_t CFG_ADDR = 8'h40;
   localparam addr_t STATUS_ADDR = 8'h41;
   localparam addr_t MASK_ADDR = 8'h43;

   // reset values
   localparam byte_t CFG_RESET = 8'h21;
   localparam byte_t STATUS_RESET = 8'h00;
   localparam byte_t MASK_RESET = 8'h00;
   localparam byte_t ZERO_BYTE = 8'h00;

   // configuration bits used by this block; all but soft reset (bit 4) are stored
   localparam int CFG_START_BIT = 0;
   localparam int CFG_INT_EN_BIT = 1;
   localparam int CFG_SOFT_RST_BIT = 4;
   localparam int CFG_FAN_OFF_BIT = 5;
   localparam int CFG_INV_BIT = 6;
   localparam byte_t CFG_STORED_MASK = 8'h63;

   // status bit positions
   localparam int ST_INT_LIMIT = 0;
   localparam int ST_FLAG1 = 1;
   localparam int ST_FLAG2 = 2;
   localparam int ST_INT_THERM = 3;
   localparam int ST_PIN_LEVEL = 4;
   localparam int ST_EXT_LIMIT = 5;
   localparam int ST_EXT_THERM = 6;
   localparam int ST_DIODE_FAULT = 7;
   // bits cleared by writing one, and software flag bits
   localparam byte_t W1C_BITS = 8'he9;
   localparam byte_t FLAG_BITS = 8'h06;
endpackage

// File: sim/reg_host.sv
/* host side of the register port: single-byte read and write strobes.
   assumes the block samples strobes on the rising edge of the shared clock. */
`timescale 1ns/1ps
`default_nettype none
module reg_host (
   input wire logic i_clk,
   output logic [7:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_wdata,
   output logic o_rd_valid
);
   initial begin
      o_addr = 8'hff;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'hff;
   end
   // writes carry ones to clear
   // one strobe cycle; a released bus shows the inverse, never stale data
   task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= w;
      o_rd <= !w;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask
   // read data settles the cycle after the strobe
   always_ff @(posedge i_clk) o_rd_valid <= o_rd;
endmodule
`default_nettype wire

// File: sim/testbench.sv
/* self-checking bench for the thermal interrupt status and mask block.
   assumes the register host model in reg_host.sv on the same clock. */
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("FAIL %s expected %h seen %h", n, e, g); end end
module testbench;
   import thermal_irq_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [4:0] ev = 5'h00;
   logic pin = 1'b0;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] m;
   logic wr;
   logic rd;
   logic rv;
   logic int_out;
   logic int_oe;
   logic [8:0] expq[$];
   logic [8:0] e;
   int bad_count = 0;
   int checks_done = 0;
   int pos[5] = '{0, 5, 3, 6, 7};
   always #10 i_clk = ~i_clk;
   reg_host host (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
      .o_wdata(wdata), .o_rd_valid(rv));
   thermal_interrupt_status_mask uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .i_int_limit_hit(ev[0]), .i_ext_limit_hit(ev[1]),
      .i_int_therm_hit(ev[2]), .i_ext_therm_hit(ev[3]), .i_diode_fault(ev[4]),
      .i_general_input_pin(pin), .o_int_n_out(int_out), .o_int_n_oe(int_oe));
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      host.access(a, d, 1'b1);
   endtask
   // note the expected {irq, data} before the read goes out
   task automatic chk(input logic [7:0] a, input logic ie, input logic [7:0] d);
      expq.push_back({ie, d});
      host.access(a, 8'h00, 1'b0);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      if (rv === 1'b1) begin
         e = expq.pop_front();
         `CMP("read data and irq", e, {int_oe, rdata})
         `CMP("irq level", 1'b0, int_out)
      end
   end
   // watchdog, far beyond the roughly 150 cycles the tests need
   initial begin
      #100us;
      bad_count++;
      summarize();
   end
   initial begin
      void'($urandom(32'h48b5c819));
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      chk(STATUS_ADDR, 1'b0, STATUS_RESET);
      chk(MASK_ADDR, 1'b0, MASK_RESET);
      chk(CFG_ADDR, 1'b0, CFG_RESET);
      wr_reg(STATUS_ADDR, 8'h02);
      chk(STATUS_ADDR, 1'b0, 8'h02);
      wr_reg(STATUS_ADDR, 8'h00);
      wr_reg(CFG_ADDR, 8'h23);
      for (int i = 0; i < 5; i++) begin
         @(posedge i_clk);
         ev[i] <= 1'b1;
         @(posedge i_clk);
         ev[i] <= 1'b0;
         wr_reg(STATUS_ADDR, 8'h00);
         chk(STATUS_ADDR, 1'b1, 8'h01 << pos[i]);
         wr_reg(STATUS_ADDR, 8'h01 << pos[i]);
         chk(STATUS_ADDR, 1'b0, 8'h00);
      end
      // event held across its own clear: set wins
      ev[1] <= 1'b1;
      wr_reg(STATUS_ADDR, 8'h20);
      ev[1] <= 1'b0;
      chk(STATUS_ADDR, 1'b1, 8'h20);
      wr_reg(STATUS_ADDR, 8'h20);
      wr_reg(STATUS_ADDR, FLAG_BITS);
      chk(STATUS_ADDR, 1'b1, FLAG_BITS);
      wr_reg(STATUS_ADDR, 8'h02);
      wr_reg(MASK_ADDR, 8'h02);
      chk(STATUS_ADDR, 1'b0, 8'h02);
      // live pin level, inversion; sync needs settling time
      @(posedge i_clk);
      pin <= 1'b1;
      repeat (4) @(posedge i_clk);
      chk(STATUS_ADDR, 1'b1, 8'h12);
      chk(STATUS_ADDR, 1'b1, 8'h12);
      wr_reg(CFG_ADDR, 8'h63);
      repeat (4) @(posedge i_clk);
      chk(STATUS_ADDR, 1'b0, 8'h02);
      pin <= 1'b0;
      repeat (4) @(posedge i_clk);
      for (int i = 0; i < 6; i++) begin
         m = 8'($urandom());
         wr_reg(MASK_ADDR, m);
         chk(MASK_ADDR, |(8'h12 & ~m), m);
      end
      // soft reset restores all, then unmapped offset
      wr_reg(CFG_ADDR, 8'h10);
      chk(CFG_ADDR, 1'b0, CFG_RESET);
      chk(STATUS_ADDR, 1'b0, 8'h00);
      chk(MASK_ADDR, 1'b0, 8'h00);
      wr_reg(8'h42, 8'hff);
      chk(8'h42, 1'b0, 8'h00);
      repeat (4) @(posedge i_clk);
      `CMP("pending reads", 0, expq.size())
      summarize();
   end
endmodule
`default_nettype wire
